// ### pll_status_pkg.sv
// Purpose: shared constants and carrier types for the pll status readback
// Assumes: byte-wide register access at printed offsets
// Notes:   status bits 7:6 read as zero
package pll_status_pkg;
  localparam logic [9:0] STATUS_ADDR        = 10'h01f;
  localparam logic [9:0] CTRL_ADDR          = 10'h01d;
  localparam int         CTRL_DISABLE_BIT   = 4;
  localparam int         BIT_HOLDOVER       = 5;
  localparam int         BIT_REFERENCE_TWO_SELECTED = 4;
  localparam int         BIT_CLK_ABOVE              = 3;
  localparam int         BIT_REFERENCE_TWO_ABOVE    = 2;
  localparam int         BIT_REFERENCE_ONE_ABOVE    = 1;
  localparam int         BIT_LOCKED         = 0;
  localparam logic [7:0] STATUS_RESET       = 8'h00;
  localparam logic       DISABLE_RESET      = 1'b0;
  localparam int         SYNC_STAGES        = 2;

  // raw status levels gathered from the monitors, one bit each
  typedef struct packed {
    logic holdover_active;
    logic reference_input_two_selected;
    logic clk_above_threshold;
    logic reference_input_two_above;
    logic reference_input_one_above;
    logic digital_locked;
  } status_raw_s;

  // register access request from the serial control port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// ### status_sync.sv
// Purpose: two-flop synchroniser for a bundle of status levels
// Assumes: inputs are slow levels from other logic or pins
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module status_sync (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire pll_status_pkg::status_raw_s async_i,
  output pll_status_pkg::status_raw_s      sync_o
);
  pll_status_pkg::status_raw_s meta_reg;
  pll_status_pkg::status_raw_s meta_next;
  pll_status_pkg::status_raw_s sync_reg;
  pll_status_pkg::status_raw_s sync_next;

  // next stage values
  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  // both stages reset to a constant
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule

// ### pll_status_readback.sv
// Purpose: read-only pll status register with refresh disable control
// Assumes: serial port decode delivers one-cycle rd/wr strobes
// Notes:   status snapshot frozen while the disable bit is set
// Operation
// - bit 5 shows holdover state, frozen with the other bits
// - bit 4 shows selected reference input
// - bit 3 shows clk above threshold
// - bit 2 shows reference two above threshold
// - bit 1 shows reference one above threshold
// - bit 0 shows digital lock result
// - disable bit freezes automatic status refresh
`timescale 1ns/1ns
module pll_status_readback (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  input  wire pll_status_pkg::status_raw_s status_i,
  input  wire pll_status_pkg::reg_req_s    req_i,
  output logic      [7:0]                  rdata_o,
  output logic                             rvalid_o,
  output logic                             disable_o
);
  // resampled monitor levels
  pll_status_pkg::status_raw_s synced;

  // decoded request qualifiers
  logic                        ctrl_write;
  logic                        ctrl_read;
  logic                        status_read;

  // status snapshot group
  logic [7:0]                  status_reg;
  logic [7:0]                  status_next;

  // refresh control group
  logic                        disable_reg;
  logic                        disable_next;

  // read answer group
  logic [7:0]                  rdata_reg;
  logic [7:0]                  rdata_next;
  logic                        rvalid_reg;
  logic                        rvalid_next;

  // one address compare, shared by the write and read decode
  function automatic logic addr_hit(
    input logic [9:0] addr,
    input logic [9:0] target
  );
    addr_hit = (addr == target);
  endfunction

  // monitor levels come from other logic, so resample them;
  // two cycles of latency traded for no metastable snapshot bits
  status_sync status_sync_i (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (status_i),
    .sync_o    (synced)
  );

  // request decode; the status address has no write decode at all
  assign ctrl_write  = req_i.wr && addr_hit(req_i.addr, pll_status_pkg::CTRL_ADDR);
  assign ctrl_read   = req_i.rd && addr_hit(req_i.addr, pll_status_pkg::CTRL_ADDR);
  assign status_read = req_i.rd && addr_hit(req_i.addr, pll_status_pkg::STATUS_ADDR);

  // refresh disable bit, written only at the control address
  always_comb begin
    disable_next = disable_reg;
    if (ctrl_write) begin
      disable_next = req_i.wdata[pll_status_pkg::CTRL_DISABLE_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      disable_reg <= pll_status_pkg::DISABLE_RESET;
    end else begin
      disable_reg <= disable_next;
    end
  end

  // status snapshot; uses the old disable value on a same-cycle write
  always_comb begin
    status_next = status_reg;
    // writes to the status address fall through untouched
    if (!disable_reg) begin // refresh only while enabled
      status_next = 8'h00;
      status_next[pll_status_pkg::BIT_HOLDOVER] =
        synced.holdover_active;
      status_next[pll_status_pkg::BIT_REFERENCE_TWO_SELECTED] =
        synced.reference_input_two_selected;
      status_next[pll_status_pkg::BIT_CLK_ABOVE] =
        synced.clk_above_threshold;
      status_next[pll_status_pkg::BIT_REFERENCE_TWO_ABOVE] =
        synced.reference_input_two_above;
      status_next[pll_status_pkg::BIT_REFERENCE_ONE_ABOVE] =
        synced.reference_input_one_above;
      status_next[pll_status_pkg::BIT_LOCKED] =
        synced.digital_locked;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= pll_status_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    rdata_next  = 8'h00;
    rvalid_next = req_i.rd;
    if (status_read) begin
      rdata_next = status_reg;
    end else if (ctrl_read) begin
      rdata_next[pll_status_pkg::CTRL_DISABLE_BIT] = disable_reg;
    end
  end

  // read answer stands for exactly one cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // outputs come straight from their flip-flops
  assign rdata_o   = rdata_reg;
  assign rvalid_o  = rvalid_reg;
  assign disable_o = disable_reg;
endmodule

// ### pll_status_readback_assertions.sv
// Purpose: port checks on the status readback
// Assumes: status steady four edges before a read
// Notes: bind at the foot
`timescale 1ns/1ns
module pll_status_readback_assertions (
  input wire logic                        ref_clk_i,
  input wire logic                        rst_i,
  input wire pll_status_pkg::status_raw_s status_i,
  input wire pll_status_pkg::reg_req_s    req_i,
  input wire logic [7:0]                  rdata_o,
  input wire logic                        rvalid_o,
  input wire logic                        disable_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // live status read; a frozen snapshot is not comparable
  wire logic r = req_i.rd && req_i.addr == pll_status_pkg::STATUS_ADDR && !disable_o;
  chk_read_answer: assert property(req_i.rd |=> rvalid_o) else $error("rvalid");
  chk_hold_bit: assert property(r|=>rdata_o[5]==$past(status_i[5],4))else $error("b5");
  chk_sel_bit: assert property(r|=>rdata_o[4]==$past(status_i[4],4))else $error("b4");
  chk_clk_bit: assert property(r|=>rdata_o[3]==$past(status_i[3],4))else $error("b3");
  chk_reference_input_two_bit: assert property(r|=>rdata_o[2]==$past(status_i[2],4))else $error("b2");
  chk_reference_input_one_bit: assert property(r|=>rdata_o[1]==$past(status_i[1],4))else $error("b1");
  chk_lock_bit: assert property(r|=>rdata_o[0]==$past(status_i[0],4))else $error("b0");
  chk_ctrl_write: assert property(req_i.wr&&req_i.addr==pll_status_pkg::CTRL_ADDR
    |=>disable_o==$past(req_i.wdata[pll_status_pkg::CTRL_DISABLE_BIT]))else $error("ctl");
  chk_status_wr: assert property(req_i.wr&&req_i.addr==pll_status_pkg::STATUS_ADDR
    |=>$stable(disable_o)&&!rvalid_o)else $error("wr");
endmodule
bind pll_status_readback pll_status_readback_assertions pll_status_readback_assertions_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .status_i(status_i), .req_i(req_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .disable_o(disable_o));

// ### pll_status_readback_test.sv
// Purpose: directed bench for the status readback
// Assumes: two reset cycles
// Notes: status held five edges before reads
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module pll_status_readback_test;
  logic                        ref_clk_i = 1'b0;
  logic                        rst_i = 1'b1;
  pll_status_pkg::status_raw_s status_i = '0;
  pll_status_pkg::reg_req_s    req_i = '0;
  logic [7:0]                  rdata_o;
  logic                        rvalid_o;
  logic                        disable_o;
  int                          errors = 0;
  int                          checks_done = 0;
  int                          cyc = 0;
  pll_status_readback pll_status_readback_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .status_i(status_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .disable_o(disable_o));
  // clock and hang guard
  initial forever #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      summarize();
    end
  end
  // one request; a read is judged in its answer cycle
  task automatic rq(input logic w, input logic [9:0] a, input logic [7:0] d, e);
    @(posedge ref_clk_i) req_i <= {w, ~w, a, d};
    @(posedge ref_clk_i) req_i <= '0;
    #1 if (!w) `CHK(rdata_o, e)
    `CHK(rvalid_o, ~w)
  endtask
  task automatic t_bits();
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk_i) status_i <= 6'h01 << i;
      repeat (5) @(posedge ref_clk_i);
      rq(0, 10'h01f, 8'h00, 8'h01 << i);
    end
  endtask
  task automatic t_freeze();
    rq(0, 10'h01d, 8'h00, 8'h00);
    rq(1, 10'h01d, 8'h10, 8'h00);
    `CHK(disable_o, 1'b1)
    rq(0, 10'h01d, 8'h00, 8'h10);
    @(posedge ref_clk_i) status_i <= 6'h2a;
    repeat (5) @(posedge ref_clk_i);
    rq(0, 10'h01f, 8'h00, 8'h20);
    rq(1, 10'h01d, 8'h00, 8'h00);
    `CHK(disable_o, 1'b0)
    repeat (5) @(posedge ref_clk_i);
    rq(0, 10'h01f, 8'h00, 8'h2a);
  endtask
  task automatic t_wr();
    rq(1, 10'h01f, 8'h15, 8'h00);
    rq(0, 10'h01f, 8'h00, 8'h2a);
    rq(0, 10'h000, 8'h00, 8'h00);
  endtask
  task automatic summarize();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_bits();
    t_freeze();
    t_wr();
    summarize();
  end
endmodule
